//--- rtl/rxpo_device.sv
// receive payload output port of one DS3 framer channel (device end)
// assumes the framer core hands over inbound bits on the recovered line
// clock, which runs at twice the DS3 bit rate; reset_i is synchronous to it
`timescale 1ns/1ns
`default_nettype none

module rxpo_device
  import rxpo_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  // link clock and reset
  input wire logic recovered_line_clock_i,
  input wire logic reset_i,
  // inbound stream from the framer core
  input wire logic in_bit_i,
  input wire logic in_overhead_i,
  input wire logic in_sof_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // terminal equipment pins
  rxpo_link_if.device link
);
  logic mode_s1_reg;
  logic nib_mode_reg;

  logic [ENTRY_W-1:0] head;
  logic head_valid;
  logic pop;

  logic ser_phase_reg;
  logic ser_load;
  logic ser_bit_reg;
  logic marker_reg;

  logic [NIB_W-1:0] acc_reg;
  logic [2:0] acc_cnt_reg;
  logic acc_sof_reg;
  logic pend_sof_reg;
  logic nib_pop;
  logic nib_load;
  logic [2:0] slot_reg;
  logic [NIB_W-1:0] nib_bus_reg;

  logic frame_reg;
  logic port_clk_reg;

  // a word waiting on a slow output slot stalls the framer, not drops
  rxpo_buffer #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH)
  ) u_buffer (
    .clk_i(recovered_line_clock_i),
    .reset_i(reset_i),
    .wr_data_i({in_sof_i, in_overhead_i, in_bit_i}),
    .wr_valid_i(in_valid_i),
    .wr_ready_o(in_ready_o),
    .rd_data_o(head),
    .rd_valid_o(head_valid),
    .rd_ready_i(pop)
  );

  // mode select is a pin from the terminal's domain
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i) begin
      mode_s1_reg <= 1'b0;
      nib_mode_reg <= 1'b0;
    end else begin
      mode_s1_reg <= link.nibble_mode_select;
      nib_mode_reg <= mode_s1_reg;
    end
  end

  assign ser_load = !nib_mode_reg && !ser_phase_reg;
  assign nib_pop = nib_mode_reg && head_valid && (acc_cnt_reg != NIB_CNT_FULL);
  assign nib_load = nib_mode_reg && (slot_reg == NIB_SLOT_IDLE) &&
                    (acc_cnt_reg == NIB_CNT_FULL);
  assign pop = (ser_load && head_valid) || nib_pop;

  // serial bit slot: two line clocks per bit, free running
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i || nib_mode_reg) begin
      ser_phase_reg <= 1'b0;
    end else begin
      ser_phase_reg <= ~ser_phase_reg;
    end
  end

  // serial data and overhead marker, loaded as the port clock rises
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i || nib_mode_reg) begin
      ser_bit_reg <= 1'b0;
      marker_reg <= 1'b0;
    end else if (ser_load) begin
      if (head_valid) begin
        ser_bit_reg <= head[ENTRY_BIT_POS];
        marker_reg <= head[ENTRY_OH_POS];
      end else begin
        // an underrun still needs a clock; flag the filler as overhead
        ser_bit_reg <= 1'b0;
        marker_reg <= 1'b1;
      end
    end
  end

  // nibble assembly: overhead bits are dropped, earliest bit ends in MSB
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i || !nib_mode_reg) begin
      acc_reg <= '0;
      acc_cnt_reg <= '0;
      acc_sof_reg <= 1'b0;
      pend_sof_reg <= 1'b0;
    end else if (nib_load) begin
      acc_cnt_reg <= '0;
    end else if (nib_pop) begin
      if (head[ENTRY_OH_POS]) begin
        pend_sof_reg <= pend_sof_reg | head[ENTRY_SOF_POS];
      end else begin
        acc_reg <= {acc_reg[NIB_W-2:0], head[ENTRY_BIT_POS]};
        acc_cnt_reg <= acc_cnt_reg + 3'h1;
        if (acc_cnt_reg == '0) begin
          acc_sof_reg <= pend_sof_reg | head[ENTRY_SOF_POS];
          pend_sof_reg <= 1'b0;
        end else begin
          pend_sof_reg <= pend_sof_reg | head[ENTRY_SOF_POS];
        end
      end
    end
  end

  // nibble slot counter: load at the falling edge, high for the last two
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i || !nib_mode_reg) begin
      slot_reg <= NIB_SLOT_IDLE;
    end else if (nib_load) begin
      slot_reg <= NIB_SLOT_FIRST;
    end else if (slot_reg != NIB_SLOT_IDLE) begin
      slot_reg <= slot_reg + 3'h1;
    end
  end

  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i || !nib_mode_reg) begin
      nib_bus_reg <= '0;
    end else if (nib_load) begin
      nib_bus_reg <= acc_reg;
    end
  end

  // start-of-frame marker for either mode
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i) begin
      frame_reg <= 1'b0;
    end else if (ser_load) begin
      frame_reg <= head_valid && head[ENTRY_SOF_POS];
    end else if (nib_load) begin
      frame_reg <= acc_sof_reg;
    end
  end

  // port clock: half line rate in serial, one short pulse per nibble
  always_ff @(posedge recovered_line_clock_i) begin
    if (reset_i) begin
      port_clk_reg <= 1'b0;
    end else if (nib_mode_reg) begin
      port_clk_reg <= (slot_reg == NIB_CLK_RISE) ||
                      (slot_reg == NIB_CLK_HOLD);
    end else begin
      port_clk_reg <= ~ser_phase_reg;
    end
  end

  assign link.rx_payload_port_clock = port_clk_reg;
  assign link.rx_serial_payload_out = ser_bit_reg;
  assign link.rx_overhead_bit_marker = marker_reg;
  assign link.rx_payload_nibble_bus = nib_bus_reg;
  assign link.rx_start_of_frame_pulse = frame_reg;

endmodule

`default_nettype wire

//--- rtl/rxpo_pkg.sv
// constants shared by both ends of the receive payload output port
// assumes a DS3 framer core that delivers inbound bits one at a time
package rxpo_pkg;

  // payload nibble width on the parallel bus
  localparam int NIB_W = 4;
  // entries in the buffer ahead of the output logic
  localparam int BUF_DEPTH = 2;

  // layout of one inbound stream entry
  localparam int ENTRY_W = 3;
  localparam int ENTRY_BIT_POS = 0;
  localparam int ENTRY_OH_POS = 1;
  localparam int ENTRY_SOF_POS = 2;

  // nibble slot: eight line clocks; the port clock is set from the last
  // two slots so that it falls on the same edge as the next bus load
  localparam logic [2:0] NIB_SLOT_IDLE = 3'h0;
  localparam logic [2:0] NIB_SLOT_FIRST = 3'h1;
  localparam logic [2:0] NIB_CLK_RISE = 3'h6;
  localparam logic [2:0] NIB_CLK_HOLD = 3'h7;
  localparam logic [2:0] NIB_CNT_FULL = 3'h4;

  // terminal side groups four serial payload bits into one word
  localparam logic [1:0] WORD_LAST = 2'h3;

  // reference figures of the port
  localparam int DS3_BIT_RATE_HZ = 44736000;
  localparam int NIBBLES_PER_FRAME = 1176;

endpackage

//--- rtl/rxpo_link_if.sv
// pins between the framer's receive payload port and terminal equipment
// assumes the testbench instantiates it and joins both ends to it
`timescale 1ns/1ns
`default_nettype none

interface rxpo_link_if;
  import rxpo_pkg::*;

  logic rx_payload_port_clock;
  logic rx_serial_payload_out;
  logic [NIB_W-1:0] rx_payload_nibble_bus;
  logic rx_overhead_bit_marker;
  logic rx_start_of_frame_pulse;
  logic nibble_mode_select;

  modport device (
    output rx_payload_port_clock,
    output rx_serial_payload_out,
    output rx_payload_nibble_bus,
    output rx_overhead_bit_marker,
    output rx_start_of_frame_pulse,
    input nibble_mode_select
  );

  modport terminal (
    input rx_payload_port_clock,
    input rx_serial_payload_out,
    input rx_payload_nibble_bus,
    input rx_overhead_bit_marker,
    input rx_start_of_frame_pulse,
    output nibble_mode_select
  );

endinterface

`default_nettype wire

//--- rtl/rxpo_buffer.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes both sides share one clock and a synchronous reset
`timescale 1ns/1ns
`default_nettype none

module rxpo_buffer #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // filling side
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  // draining side
  output logic [WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pull;

  assign wr_ready_o = (count_reg != FULL_COUNT);
  assign rd_valid_o = (count_reg != '0);
  assign rd_data_o = mem[rd_ptr_reg];
  assign push = wr_valid_i & wr_ready_o;
  assign pull = rd_valid_o & rd_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pull) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
    end else if (push && !pull) begin
      count_reg <= count_reg + (AW+1)'(1);
    end else if (pull && !push) begin
      count_reg <= count_reg - (AW+1)'(1);
    end
  end

endmodule

`default_nettype wire

//--- rtl/rxpo_terminal.sv
// terminal equipment end: captures receive payload from the port
// assumes the port clock comes from the device and may stop between
// nibbles; words are handed to clk_i by a toggle crossing
`timescale 1ns/1ns
`default_nettype none

module rxpo_terminal
  import rxpo_pkg::*;
(
  // system clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // configuration
  input wire logic nibble_mode_i,
  // received payload words
  output logic [NIB_W-1:0] word_o,
  output logic word_sof_o,
  output logic word_valid_o,
  // device pins
  rxpo_link_if.terminal link
);
  wire port_clk = link.rx_payload_port_clock;

  logic lk_rst_s1_reg;
  logic lk_rst_reg;
  logic lk_mode_s1_reg;
  logic lk_mode_reg;
  logic ser_bit_n_reg;
  logic ser_mark_n_reg;
  logic ser_sof_n_reg;
  logic [2:0] acc_reg;
  logic [1:0] cnt_reg;
  logic acc_sof_reg;
  logic pend_reg;
  logic ser_take;
  logic ser_done;
  logic [NIB_W-1:0] hold_word_reg;
  logic hold_sof_reg;
  logic tog_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  assign link.nibble_mode_select = nibble_mode_i;

  // reset and mode level crossings into the port clock domain
  always_ff @(posedge port_clk) begin
    lk_rst_s1_reg <= reset_i;
    lk_rst_reg <= lk_rst_s1_reg;
    lk_mode_s1_reg <= nibble_mode_i;
    lk_mode_reg <= lk_mode_s1_reg;
  end

  // serial pins are sampled half a period after the device moves them
  always_ff @(negedge port_clk) begin
    if (lk_rst_reg) begin
      ser_bit_n_reg <= 1'b0;
      ser_mark_n_reg <= 1'b1;
      ser_sof_n_reg <= 1'b0;
    end else begin
      ser_bit_n_reg <= link.rx_serial_payload_out;
      ser_mark_n_reg <= link.rx_overhead_bit_marker;
      ser_sof_n_reg <= link.rx_start_of_frame_pulse;
    end
  end

  assign ser_take = !lk_mode_reg && !ser_mark_n_reg;
  assign ser_done = ser_take && (cnt_reg == WORD_LAST);

  // serial payload bits gather into words, earliest bit in the MSB
  always_ff @(posedge port_clk) begin
    if (lk_rst_reg || lk_mode_reg) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      acc_sof_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (ser_take) begin
      acc_reg <= {acc_reg[1:0], ser_bit_n_reg};
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == '0) begin
        acc_sof_reg <= pend_reg | ser_sof_n_reg;
        pend_reg <= 1'b0;
      end else begin
        pend_reg <= pend_reg | ser_sof_n_reg;
      end
    end else begin
      pend_reg <= pend_reg | ser_sof_n_reg;
    end
  end

  // finished word is held while the toggle crosses to clk_i; the port
  // clock stops between nibbles, so the synced reset may lag by two
  // nibbles and nibble capture does not wait for it
  always_ff @(posedge port_clk) begin
    if (lk_mode_reg) begin
      hold_word_reg <= link.rx_payload_nibble_bus;
      hold_sof_reg <= link.rx_start_of_frame_pulse;
      tog_reg <= ~tog_reg;
    end else if (lk_rst_reg) begin
      hold_word_reg <= '0;
      hold_sof_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else if (ser_done) begin
      hold_word_reg <= {acc_reg, ser_bit_n_reg};
      hold_sof_reg <= (cnt_reg == '0) ? (pend_reg | ser_sof_n_reg)
                                      : acc_sof_reg;
      tog_reg <= ~tog_reg;
    end
  end

  // hold register changes at most every four bits, well after the
  // three clk_i edges the toggle needs to arrive; the chain is not reset
  // so it tracks the toggle during reset and no false word follows release
  always_ff @(posedge clk_i) begin
    tog_s1_reg <= tog_reg;
    tog_s2_reg <= tog_s1_reg;
    tog_s3_reg <= tog_s2_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      word_o <= '0;
      word_sof_o <= 1'b0;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= tog_s2_reg ^ tog_s3_reg;
      if (tog_s2_reg ^ tog_s3_reg) begin
        word_o <= hold_word_reg;
        word_sof_o <= hold_sof_reg;
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/rxpo_link_monitor.sv
// checker on the receive payload link between device and terminal
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ns
`default_nettype none

module rxpo_link_monitor
  import rxpo_pkg::*;
(
  // link clock and reset
  input wire logic line_clk_i,
  input wire logic line_reset_i,
  // link signals
  input wire logic rx_payload_port_clock,
  input wire logic rx_serial_payload_out,
  input wire logic [NIB_W-1:0] rx_payload_nibble_bus,
  input wire logic rx_overhead_bit_marker,
  input wire logic rx_start_of_frame_pulse,
  input wire logic nibble_mode_select
);
  logic [2:0] settle_reg;
  logic nib;
  logic ser;

  // mode select is synchronised in the device; skip the first edges
  always_ff @(posedge line_clk_i) begin
    if (line_reset_i) begin
      settle_reg <= 3'h0;
    end else if (settle_reg != 3'h7) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end
  assign nib = (settle_reg == 3'h7) && nibble_mode_select;
  assign ser = (settle_reg == 3'h7) && !nibble_mode_select;

  default clocking @(posedge line_clk_i); endclocking
  default disable iff (line_reset_i);

  ser_quiet_a: assert property (nib |-> !rx_serial_payload_out)
    else $error("serial line active in nibble mode");
  nib_quiet_a: assert property (ser |-> rx_payload_nibble_bus == 4'h0)
    else $error("nibble bus active in serial mode");
  mark_low_a: assert property (nib |-> !rx_overhead_bit_marker)
    else $error("marker high in nibble mode");
  ser_clk_a: assert property (ser |=> $changed(rx_payload_port_clock))
    else $error("serial port clock stalled");
  ser_bit_a: assert property (ser && $changed(rx_serial_payload_out)
    |-> $rose(rx_payload_port_clock))
    else $error("serial bit changed off the rising edge");
  ser_mark_a: assert property (ser && $changed(rx_overhead_bit_marker)
    |-> $rose(rx_payload_port_clock))
    else $error("marker changed off the rising edge");
  ser_sof_a: assert property (ser && $rose(rx_start_of_frame_pulse)
    |-> $rose(rx_payload_port_clock) ##1 rx_start_of_frame_pulse
    ##1 !rx_start_of_frame_pulse)
    else $error("serial frame pulse not one bit long");
  nib_hold_a: assert property (nib && rx_payload_port_clock
    |-> $stable(rx_payload_nibble_bus) && $stable(rx_start_of_frame_pulse))
    else $error("nibble bus moved while port clock high");
  nib_duty_a: assert property (nib && $rose(rx_payload_port_clock)
    |-> ##1 rx_payload_port_clock ##1 !rx_payload_port_clock [*6])
    else $error("nibble port clock shape wrong");

  cover property (ser && $rose(rx_start_of_frame_pulse));
  cover property (nib && $rose(rx_start_of_frame_pulse));
  cover property (ser && rx_overhead_bit_marker && $rose(rx_payload_port_clock));
endmodule

`default_nettype wire

//--- testbench/test_rxpo.sv
// bench joining device and terminal ends; words compared in order
// assumes the rtl files are compiled first
`timescale 1ns/1ns
`default_nettype none

module test_rxpo;
  import rxpo_pkg::*;

  localparam int FRAME_BITS = 4760;
  localparam int OH_SPACING = 85;

  logic clk_i;
  logic reset_i;
  logic line_clk;
  logic line_reset;
  logic mode;
  logic in_bit, in_oh, in_sof, in_valid, in_ready;
  logic [NIB_W-1:0] word;
  logic word_sof, word_valid;
  logic [NIB_W:0] expq[$];
  logic [NIB_W:0] want;
  int mismatches, total_checks, pulses;

  rxpo_link_if link ();

  rxpo_device u_rxpo_device (
    .recovered_line_clock_i(line_clk),
    .reset_i(line_reset),
    .in_bit_i(in_bit),
    .in_overhead_i(in_oh),
    .in_sof_i(in_sof),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .link(link)
  );

  rxpo_terminal u_rxpo_terminal (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .nibble_mode_i(mode),
    .word_o(word),
    .word_sof_o(word_sof),
    .word_valid_o(word_valid),
    .link(link)
  );

  rxpo_link_monitor u_rxpo_link_monitor (
    .line_clk_i(line_clk),
    .line_reset_i(line_reset),
    .rx_payload_port_clock(link.rx_payload_port_clock),
    .rx_serial_payload_out(link.rx_serial_payload_out),
    .rx_payload_nibble_bus(link.rx_payload_nibble_bus),
    .rx_overhead_bit_marker(link.rx_overhead_bit_marker),
    .rx_start_of_frame_pulse(link.rx_start_of_frame_pulse),
    .nibble_mode_select(link.nibble_mode_select)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // link clock offset so its edges never meet the system clock's
  initial begin
    line_clk = 1'b0;
    #3;
    forever #6 line_clk = ~line_clk;
  end

  task automatic fail(input string msg);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one frame: an overhead bit every 85 positions, random payload,
  // random idle gaps so serial underruns and nibble stalls occur
  task automatic send_frame();
    logic [NIB_W-1:0] acc;
    logic first;
    int n;
    acc = 4'h0;
    first = 1'b1;
    n = 0;
    for (int i = 0; i < FRAME_BITS; i++) begin
      if ($urandom_range(63) == 0) begin
        in_valid = 1'b0;
        repeat (6) @(negedge line_clk);
      end
      in_bit = 1'($urandom_range(1));
      in_oh = (i % OH_SPACING == 0);
      in_sof = (i == 0);
      in_valid = 1'b1;
      if (!in_oh) begin
        acc = {acc[NIB_W-2:0], in_bit};
        n++;
        if (n % NIB_W == 0) begin
          expq.push_back({first, acc});
          first = 1'b0;
        end
      end
      // in_ready is settled between rising edges; hold until taken
      while (in_ready !== 1'b1) @(negedge line_clk);
      @(negedge line_clk);
    end
    in_valid = 1'b0;
  endtask

  // filler payload with no expectation: in nibble mode the port clock only
  // runs on data, and the terminal link side needs edges to see reset/mode
  task automatic warm_up();
    repeat (4) @(negedge line_clk);
    for (int i = 0; i < 3 * NIB_W; i++) begin
      in_bit = 1'($urandom_range(1));
      in_oh = 1'b0;
      in_sof = 1'b0;
      in_valid = 1'b1;
      while (in_ready !== 1'b1) @(negedge line_clk);
      @(negedge line_clk);
    end
    in_valid = 1'b0;
    repeat (30) @(negedge clk_i);
  endtask

  task automatic run(input logic m);
    @(negedge line_clk);
    line_reset = 1'b1;
    @(negedge clk_i);
    reset_i = 1'b1;
    mode = m;
    repeat (5) @(negedge clk_i);
    @(negedge line_clk);
    line_reset = 1'b0;
    // terminal link side needs port clock edges to leave reset
    if (m) warm_up();
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    pulses = 0;
    send_frame();
    repeat (200) @(negedge clk_i);
    total_checks++;
    if (expq.size() != 0) fail("payload words missing");
    expq.delete();
  endtask

  always @(negedge clk_i) begin
    if (word_valid === 1'b1) begin
      if (expq.size() == 0) begin
        fail("word not expected");
      end else begin
        want = expq.pop_front();
        total_checks++;
        if ({word_sof, word} !== want) fail("word or frame flag");
      end
    end
  end

  always @(posedge link.rx_payload_port_clock) begin
    if (mode === 1'b1) pulses++;
  end

  initial begin
    mode = 1'b0;
    reset_i = 1'b1;
    line_reset = 1'b1;
    in_bit = 1'b0;
    in_oh = 1'b0;
    in_sof = 1'b0;
    in_valid = 1'b0;
    mismatches = 0;
    total_checks = 0;
    pulses = 0;
    void'($urandom(32'hC241));
    run(1'b0);
    run(1'b1);
    total_checks++;
    if (pulses != NIBBLES_PER_FRAME) fail("nibble clock count");
    final_report();
  end

  initial begin
    #600000;
    fail("run did not finish");
    final_report();
  end
endmodule

`default_nettype wire
